/* src/tmw_core.sv */
// tmw_core: wishbone slave that turns software orders into device instructions
// assumes classic wishbone on mclk; refuses orders that would break the timer usage rules
`timescale 1ns/1ps
`default_nettype none
module tmw_core
  import tmw_pkg::*;
#(
  parameter int KICK_CYC = 60000
) (
  input  wire logic        mclk,
  input  wire logic        nrst,
  tmw_if.core              bus,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o
);
  // the auto restart must land well inside the watchdog period
  if (KICK_CYC < 1 || KICK_CYC >= WDT_MAX_CYC - 8) begin : g_bad_kick
    $error("tmw_core: KICK_CYC out of range");
  end

  logic [13:0] seq_q [4];
  logic [2:0]  seq_n_q;
  logic [1:0]  cfg_q;
  logic        skip_q;
  logic        err_q;
  logic        t1ev_q;
  logic        t3ev_q;
  logic [7:0]  last_rd_q;
  logic [3:0]  run_sh_q;
  logic [3:0]  src_sh_q;
  logic [3:0]  opt_sh_q;
  logic        rld4h_nz_q;
  logic [16:0] kick_q;
  logic        acc;
  logic        cmd_wr;
  logic        stat_wr;
  logic [3:0]  op;
  logic [1:0]  sel;
  logic [7:0]  dat;
  logic        busy_t;
  logic        illegal;
  logic        kick_due;
  logic        hazard;
  logic [13:0] head;

  assign acc     = wb_cyc_i & wb_stb_i & wb_ack_o;
  assign cmd_wr  = acc & wb_we_i & (wb_adr_i == ADR_CMD) & wb_sel_i[0];
  assign stat_wr = acc & wb_we_i & (wb_adr_i == ADR_STAT) & wb_sel_i[1];
  assign op      = wb_dat_i[CMD_OP_LSB +: 4];
  assign sel     = wb_dat_i[CMD_SEL_LSB +: 2];
  assign dat     = wb_dat_i[CMD_DAT_LSB +: 8];
  assign busy_t  = run_sh_q[sel] | (sel == TI_T3 && opt_sh_q[TI_T3]);
  assign kick_due = cfg_q[CFG_KICK] && (kick_q >= 17'(KICK_CYC)) && (seq_n_q == 3'h0) && !cmd_wr;
  assign head    = seq_q[0];
  assign hazard  = (head[3:0] == OP_RLD_WR || head[3:0] == OP_RLDH_WR ||
                    (head[3:0] == OP_CTRL_WR && head[5:4] == TI_T4)) && bus.uf_near[head[5:4]];

  always_comb begin
    illegal = (seq_n_q != 3'h0);
    unique case (op)
      OP_T_RD, OP_T_WR: illegal = illegal | busy_t;
      OP_CTRL_WR: begin
        illegal = illegal | (busy_t && dat[CB_SRC] != src_sh_q[sel]);
        illegal = illegal | (sel == TI_T4 && dat[CB_OPT] && !rld4h_nz_q);
      end
      OP_RLDH_WR: illegal = illegal | (opt_sh_q[TI_T4] && dat == 8'h00);
      default: illegal = illegal | (op > OP_RLDH_WR);
    endcase
  end

  // order expansion: disable and power-down carry their mandatory restart
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      for (int i = 0; i < 4; i++) seq_q[i] <= 14'h0;
      seq_n_q <= 3'h0;
    end else if (cmd_wr && !illegal) begin
      seq_q[0] <= {dat, sel, op};
      seq_n_q  <= 3'h1;
      if (op == OP_WATCHDOG_DISABLE_INSTR) begin
        seq_q[1] <= {8'h00, 2'h0, OP_WATCHDOG_RESTART_INSTR};
        seq_n_q  <= 3'h2;
      end else if (op == OP_PDOWN) begin
        seq_q[0] <= {8'h00, 2'h0, OP_WATCHDOG_RESTART_INSTR};
        seq_q[1] <= {dat, sel, op};
        seq_n_q  <= 3'h2;
      end else if (op == OP_WAKE && cfg_q[CFG_WDOFF]) begin
        seq_q[1] <= {8'h00, 2'h0, OP_WATCHDOG_DISABLE_INSTR};
        seq_q[2] <= {8'h00, 2'h0, OP_WATCHDOG_RESTART_INSTR};
        seq_q[3] <= {8'h00, 2'h0, OP_CLRWEF};
        seq_n_q  <= 3'h4;
      end
    end else if (kick_due) begin
      seq_q[0] <= {8'h00, 2'h0, OP_WATCHDOG_RESTART_INSTR};
      seq_n_q  <= 3'h1;
    end else if (seq_n_q != 3'h0 && !hazard) begin
      for (int i = 0; i < 3; i++) seq_q[i] <= seq_q[i+1];
      seq_n_q <= seq_n_q - 3'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      bus.cmd_valid <= 1'b0;
      bus.cmd_op    <= OP_NOP;
      bus.cmd_sel   <= 2'h0;
      bus.cmd_data  <= 8'h00;
    end else begin
      bus.cmd_valid <= (seq_n_q != 3'h0) && !hazard;
      bus.cmd_op    <= head[3:0];
      bus.cmd_sel   <= head[5:4];
      bus.cmd_data  <= head[13:6];
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      kick_q <= 17'h0;
    end else if (bus.cmd_valid && bus.cmd_op == OP_WATCHDOG_RESTART_INSTR) begin
      kick_q <= 17'h0;
    end else if (cfg_q[CFG_KICK] && kick_q != 17'h1ffff) begin
      kick_q <= kick_q + 17'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      run_sh_q   <= 4'h0;
      src_sh_q   <= 4'h0;
      opt_sh_q   <= 4'h0;
      rld4h_nz_q <= 1'b1;
    end else if (cmd_wr && !illegal) begin
      if (op == OP_CTRL_WR) begin
        run_sh_q[sel] <= dat[CB_RUN];
        src_sh_q[sel] <= dat[CB_SRC];
        opt_sh_q[sel] <= dat[CB_OPT];
      end
      if (op == OP_RLDH_WR) rld4h_nz_q <= (dat != 8'h00);
    end
  end

  // sticky status: a new event in the clearing cycle wins
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      skip_q    <= 1'b0;
      err_q     <= 1'b0;
      t1ev_q    <= 1'b0;
      t3ev_q    <= 1'b0;
      last_rd_q <= 8'h00;
      cfg_q     <= CFG_RST;
    end else begin
      skip_q <= bus.skip   | (skip_q & ~(stat_wr & wb_dat_i[ST_SKIP]));
      err_q  <= (cmd_wr & illegal) | (err_q & ~(stat_wr & wb_dat_i[ST_ERR]));
      t1ev_q <= bus.t1_irq | (t1ev_q & ~(stat_wr & wb_dat_i[ST_T1EV]));
      t3ev_q <= bus.t3_irq | (t3ev_q & ~(stat_wr & wb_dat_i[ST_T3EV]));
      if (bus.rd_valid) last_rd_q <= bus.rd_data;
      if (acc && wb_we_i && wb_adr_i == ADR_CFG && wb_sel_i[0]) cfg_q <= wb_dat_i[1:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
        unique case (wb_adr_i)
          ADR_STAT: wb_dat_o <= {16'h0, t3ev_q, t1ev_q, (seq_n_q != 3'h0), bus.wd_rst,
                                 bus.second_underflow_flag, bus.first_underflow_flag, err_q, skip_q, last_rd_q};
          ADR_CFG:  wb_dat_o <= {30'h0, cfg_q};
          default:  wb_dat_o <= 32'h0;
        endcase
      end
    end
  end
endmodule : tmw_core
`default_nettype wire

/* src/tmw_dev.sv */
// tmw_dev: prescaler, timers 1/3/4 and two-stage watchdog, driven by one instruction per cycle
// assumes mclk is the instruction clock; reset pin is open drain, resolved outside
// Contract
// - watchdog counts down from reset release
// - first underflow sets first flag
// - restart clears first flag, skips next
// - watchdog reset drives reset pin low
// - watchdog decrements once per instruction clock
// - software restarts within 65534 cycles
// - disable needs disable+restart pair, clear enable
// - watchdog re-armed after power-down return
// - restart before entering power-down
// - stop prescaler before reading or writing
// - stop timer before changing count source
// - stop timer before reading its count
// - stop timer before writing its count
// - reload writes avoid the underflow moment
// - never stop timer 4 at underflow
// - extension on needs high reload nonzero
// - stop timer 5 before source change
// - port C latch zero for pulse output
// - timer 1 counts first event pin rises
// - timer 3 started by second trigger
//
// The register addresses and the Wishbone register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module tmw_dev
  import tmw_pkg::*;
#(
  parameter logic [15:0] WDT_INIT = WDT_INIT_DEF
) (
  input  wire logic mclk,
  input  wire logic nrst,
  tmw_if.dev        bus,
  input  wire logic event_pin_first,
  input  wire logic external_trigger_second,
  output logic      rst_pin_o,
  output logic      rst_pin_oe_n,
  output logic      pwm_o
);
  // a zero start value would underflow on the first enabled cycle
  if (WDT_INIT == 16'h0000) begin : g_bad_init
    $error("tmw_dev: WDT_INIT must be nonzero");
  end

  logic [1:0]  ev_sync_q;
  logic [1:0]  tg_sync_q;
  logic        ev_last_q;
  logic        tg_last_q;
  logic        ev_rise;
  logic        tg_rise;
  logic [15:0] wdt_q;
  logic        first_underflow_flag_q;
  logic        second_underflow_flag_q;
  logic        wef_q;
  logic        pdown_q;
  logic        watchdog_disable_instr_last_q;
  logic        disarm_q;
  logic [7:0]  rst_cnt_q;
  logic [7:0]  rst_cnt_d;
  logic        wdt_run;
  logic        wdt_uf;
  logic        rst_end;
  logic [7:0]  cnt_q [4];
  logic [7:0]  rld_q [4];
  logic [7:0]  rl    [4];
  logic [7:0]  rld4h_q;
  logic [3:0]  run_q;
  logic [3:0]  src_q;
  logic [3:0]  opt_q;
  logic [3:0]  tick;
  logic [3:0]  uf;
  logic        ps_uf;
  logic        pwm_q;
  logic        stretch_q;

  function automatic logic is_op(input logic [3:0] op);
    is_op = bus.cmd_valid && (bus.cmd_op == op);
  endfunction : is_op

  // pins are asynchronous: two flops before any logic looks at them
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      ev_sync_q <= 2'h0;
      tg_sync_q <= 2'h0;
      ev_last_q <= 1'b0;
      tg_last_q <= 1'b0;
    end else begin
      ev_sync_q <= {ev_sync_q[0], event_pin_first};
      tg_sync_q <= {tg_sync_q[0], external_trigger_second};
      ev_last_q <= ev_sync_q[1];
      tg_last_q <= tg_sync_q[1];
    end
  end
  assign ev_rise = ev_sync_q[1] & ~ev_last_q;
  assign tg_rise = tg_sync_q[1] & ~tg_last_q;

  // ---------------- watchdog ----------------
  assign wdt_run = wef_q & ~pdown_q & (rst_cnt_q == 8'h00);
  assign wdt_uf  = wdt_run & (wdt_q == 16'h0000);
  assign rst_end = (rst_cnt_q == 8'h01);

  always_comb begin
    rst_cnt_d = rst_cnt_q;
    if (wdt_uf && first_underflow_flag_q) begin
      rst_cnt_d = WDRST_CYC;
    end else if (rst_cnt_q != 8'h00) begin
      rst_cnt_d = rst_cnt_q - 8'h01;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      wdt_q <= WDT_INIT;
    end else if (rst_end || wdt_uf) begin
      wdt_q <= WDT_INIT;
    end else if (wdt_run) begin
      wdt_q <= wdt_q - 16'h0001;
    end
  end

  // set wins over the restart clear so an underflow is never lost
  always_ff @(posedge mclk) begin
    if (!nrst || rst_end) begin
      first_underflow_flag_q <= 1'b0;
      second_underflow_flag_q <= 1'b0;
    end else begin
      if (wdt_uf) begin
        first_underflow_flag_q <= 1'b1;
      end else if (is_op(OP_WATCHDOG_RESTART_INSTR)) begin
        first_underflow_flag_q <= 1'b0;
      end
      if (wdt_uf && first_underflow_flag_q) begin
        second_underflow_flag_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      rst_cnt_q    <= 8'h00;
      rst_pin_o    <= 1'b0;
      rst_pin_oe_n <= 1'b1;
      bus.wd_rst   <= 1'b0;
    end else begin
      rst_cnt_q    <= rst_cnt_d;
      rst_pin_o    <= 1'b0;
      rst_pin_oe_n <= (rst_cnt_d == 8'h00);
      bus.wd_rst   <= (rst_cnt_d != 8'h00);
    end
  end

  // disable only after a disable instruction followed at once by a restart
  always_ff @(posedge mclk) begin
    if (!nrst || rst_end) begin
      wef_q       <= 1'b1;
      pdown_q     <= 1'b0;
      watchdog_disable_instr_last_q <= 1'b0;
      disarm_q    <= 1'b0;
    end else begin
      watchdog_disable_instr_last_q <= is_op(OP_WATCHDOG_DISABLE_INSTR);
      if (is_op(OP_WAKE)) begin
        pdown_q  <= 1'b0;
        wef_q    <= 1'b1;
        disarm_q <= 1'b0;
      end else begin
        if (is_op(OP_PDOWN)) pdown_q <= 1'b1;
        if (is_op(OP_WATCHDOG_RESTART_INSTR) && watchdog_disable_instr_last_q) disarm_q <= 1'b1;
        if (is_op(OP_CLRWEF) && disarm_q) wef_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      bus.skip <= 1'b0;
    end else begin
      bus.skip <= is_op(OP_WATCHDOG_RESTART_INSTR);
    end
  end

  // ---------------- timers ----------------
  always_comb begin
    tick[0] = run_q[TI_PS];
    ps_uf   = tick[0] && (cnt_q[TI_PS] == 8'h00);
    tick[1] = run_q[TI_T1] & (src_q[TI_T1] ? ev_rise : ps_uf);
    tick[2] = run_q[TI_T3] & (src_q[TI_T3] ? 1'b1 : ps_uf);
    tick[3] = run_q[TI_T4] & (src_q[TI_T4] ? ps_uf : 1'b1);
    for (int i = 0; i < 4; i++) begin
      uf[i] = tick[i] && (cnt_q[i] == 8'h00);
      rl[i] = rld_q[i];
    end
    // timer 4 alternates low/high reloads; a stretched high phase holds one extra count
    if (!pwm_q) begin
      rl[TI_T4] = rld4h_q;
    end else if (stretch_q) begin
      rl[TI_T4] = 8'h00;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      for (int i = 0; i < 4; i++) begin
        cnt_q[i] <= CNT_RST;
        rld_q[i] <= RLD_RST;
      end
      rld4h_q <= RLD_RST;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (is_op(OP_T_WR) && bus.cmd_sel == 2'(i)) begin
          cnt_q[i] <= bus.cmd_data;
        end else if (uf[i]) begin
          cnt_q[i] <= rl[i];
        end else if (tick[i]) begin
          cnt_q[i] <= cnt_q[i] - 8'h01;
        end
        if ((is_op(OP_RLD_WR) || (is_op(OP_T_WR) && i == 0)) && bus.cmd_sel == 2'(i)) begin
          rld_q[i] <= bus.cmd_data;
        end
      end
      if (is_op(OP_RLDH_WR)) rld4h_q <= bus.cmd_data;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      run_q <= 4'h0;
      src_q <= 4'h0;
      opt_q <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (is_op(OP_CTRL_WR) && bus.cmd_sel == 2'(i)) begin
          run_q[i] <= bus.cmd_data[CB_RUN];
          src_q[i] <= bus.cmd_data[CB_SRC];
          opt_q[i] <= bus.cmd_data[CB_OPT];
        end
      end
      // armed timer 3 starts on the first trigger rise; the arm is one-shot
      if (opt_q[TI_T3] && tg_rise && !(is_op(OP_CTRL_WR) && bus.cmd_sel == TI_T3)) begin
        run_q[TI_T3] <= 1'b1;
        opt_q[TI_T3] <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      pwm_q     <= 1'b0;
      stretch_q <= 1'b0;
      pwm_o     <= 1'b0;
    end else begin
      pwm_o <= pwm_q;
      if (uf[TI_T4]) begin
        if (!pwm_q) begin
          pwm_q     <= 1'b1;
          stretch_q <= opt_q[TI_T4];
        end else if (stretch_q) begin
          stretch_q <= 1'b0;
        end else begin
          pwm_q <= 1'b0;
        end
      end
    end
  end

  // near-underflow hint lets the core hold off reload writes and timer 4 control writes
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      bus.rd_valid <= 1'b0;
      bus.rd_data  <= 8'h00;
      bus.uf_near  <= 4'h0;
      bus.t1_irq   <= 1'b0;
      bus.t3_irq   <= 1'b0;
    end else begin
      bus.rd_valid <= is_op(OP_T_RD);
      if (is_op(OP_T_RD)) bus.rd_data <= cnt_q[bus.cmd_sel];
      for (int i = 0; i < 4; i++) begin
        bus.uf_near[i] <= run_q[i] && (cnt_q[i] == 8'h00);
      end
      bus.t1_irq <= uf[TI_T1];
      bus.t3_irq <= uf[TI_T3];
    end
  end

  assign bus.first_underflow_flag = first_underflow_flag_q;
  assign bus.second_underflow_flag = second_underflow_flag_q;
endmodule : tmw_dev
`default_nettype wire

/* src/tmw_if.sv */
// tmw_if: instruction link between the core-side controller and the timer/watchdog device
// assumes both ends run on mclk
`timescale 1ns/1ps
`default_nettype none
interface tmw_if (
  input wire logic mclk
);
  logic       cmd_valid;
  logic [3:0] cmd_op;
  logic [1:0] cmd_sel;
  logic [7:0] cmd_data;
  logic       rd_valid;
  logic [7:0] rd_data;
  logic       skip;
  logic [3:0] uf_near;
  logic       first_underflow_flag;
  logic       second_underflow_flag;
  logic       wd_rst;
  logic       t1_irq;
  logic       t3_irq;

  modport dev (
    input  cmd_valid, cmd_op, cmd_sel, cmd_data,
    output rd_valid, rd_data, skip, uf_near, first_underflow_flag, second_underflow_flag, wd_rst, t1_irq, t3_irq
  );
  modport core (
    output cmd_valid, cmd_op, cmd_sel, cmd_data,
    input  rd_valid, rd_data, skip, uf_near, first_underflow_flag, second_underflow_flag, wd_rst, t1_irq, t3_irq
  );
endinterface : tmw_if
`default_nettype wire

/* src/tmw_pkg.sv */
// tmw_pkg: shared constants for the timer/watchdog device and its core-side controller
// assumes one clock (mclk, 125 MHz) for both ends
package tmw_pkg;
  localparam int          CLK_NS       = 8;
  // instruction opcodes carried from core to device
  localparam logic [3:0]  OP_NOP       = 4'h0;
  localparam logic [3:0]  OP_WATCHDOG_RESTART_INSTR      = 4'h1;
  localparam logic [3:0]  OP_WATCHDOG_DISABLE_INSTR      = 4'h2;
  localparam logic [3:0]  OP_CLRWEF    = 4'h3;
  localparam logic [3:0]  OP_T_RD      = 4'h4;
  localparam logic [3:0]  OP_T_WR      = 4'h5;
  localparam logic [3:0]  OP_RLD_WR    = 4'h6;
  localparam logic [3:0]  OP_CTRL_WR   = 4'h7;
  localparam logic [3:0]  OP_PDOWN     = 4'h8;
  localparam logic [3:0]  OP_WAKE      = 4'h9;
  localparam logic [3:0]  OP_RLDH_WR   = 4'ha;
  // timer index carried in cmd_sel
  localparam logic [1:0]  TI_PS        = 2'h0;
  localparam logic [1:0]  TI_T1        = 2'h1;
  localparam logic [1:0]  TI_T3        = 2'h2;
  localparam logic [1:0]  TI_T4        = 2'h3;
  // control byte fields
  localparam int          CB_RUN       = 0;
  localparam int          CB_SRC       = 1;
  localparam int          CB_OPT       = 2;
  // watchdog
  localparam logic [15:0] WDT_INIT_DEF = 16'hffff;
  localparam int          WDT_MAX_CYC  = 65534;
  localparam int          WDRST_NS     = 128;
  localparam logic [7:0]  WDRST_CYC    = 8'((WDRST_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0]  CNT_RST      = 8'hff;
  localparam logic [7:0]  RLD_RST      = 8'hff;
  // wishbone register offsets (byte addresses)
  localparam logic [3:0]  ADR_CMD      = 4'h0;
  localparam logic [3:0]  ADR_STAT     = 4'h4;
  localparam logic [3:0]  ADR_CFG      = 4'h8;
  // CMD fields
  localparam int          CMD_OP_LSB   = 0;
  localparam int          CMD_SEL_LSB  = 4;
  localparam int          CMD_DAT_LSB  = 8;
  // STAT fields
  localparam int          ST_SKIP      = 8;
  localparam int          ST_ERR       = 9;
  localparam int          ST_FIRST_UNDERFLOW_FLAG      = 10;
  localparam int          ST_SECOND_UNDERFLOW_FLAG      = 11;
  localparam int          ST_WDRST     = 12;
  localparam int          ST_BUSY      = 13;
  localparam int          ST_T1EV      = 14;
  localparam int          ST_T3EV      = 15;
  // CFG fields
  localparam int          CFG_KICK     = 0;
  localparam int          CFG_WDOFF    = 1;
  localparam logic [1:0]  CFG_RST      = 2'h0;
endpackage : tmw_pkg

/* verif/test_timer_watchdog_control.sv */
// test_timer_watchdog_control: core and device joined by the link, driven over wishbone
// assumes small watchdog count; reset pin is not looped back to nrst
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin bad_count++; \
  $display("FAIL %s expected %0h seen %0h", nm, exp, got); end end
`define WAITC(c, lim) begin k = 0; while ((c) !== 1'b1 && k < lim) begin @(posedge mclk); k++; end \
  if ((c) !== 1'b1) timeout(); end
module test_timer_watchdog_control
  import tmw_pkg::*;
;
  localparam logic [15:0] WD_INIT = 16'h0040;
  logic        mclk, nrst, wb_cyc, wb_stb, wb_we, wb_ack, ev_pin, trig, rst_pin, rst_oe_n;
  logic [3:0]  wb_adr, wb_sel;
  logic [31:0] wb_dat, wb_rdat, q;
  int          bad_count, n_checks, k;

  tmw_if u_tmw_if (.mclk(mclk));
  tmw_dev #(.WDT_INIT(WD_INIT)) u_tmw_dev (.mclk(mclk), .nrst(nrst), .bus(u_tmw_if), .event_pin_first(ev_pin),
    .external_trigger_second(trig), .rst_pin_o(rst_pin), .rst_pin_oe_n(rst_oe_n), .pwm_o());
  tmw_core #(.KICK_CYC(20)) u_tmw_core (.mclk(mclk), .nrst(nrst), .bus(u_tmw_if), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
    .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack));
  tmw_asserts #(.WDT_INIT(WD_INIT)) u_tmw_asserts (.mclk(mclk), .nrst(nrst), .cmd_valid(u_tmw_if.cmd_valid),
    .cmd_op(u_tmw_if.cmd_op), .rd_valid(u_tmw_if.rd_valid), .skip(u_tmw_if.skip), .first_underflow_flag(u_tmw_if.first_underflow_flag),
    .second_underflow_flag(u_tmw_if.second_underflow_flag), .wd_rst(u_tmw_if.wd_rst), .rst_pin_oe_n(rst_oe_n));

  always #(CLK_NS / 2) mclk = ~mclk;

  function automatic logic [31:0] cw(input logic [3:0] op, input logic [1:0] sel, input logic [7:0] d);
    return {16'h0, d, 2'b00, sel, op};
  endfunction : cw

  task automatic results;
    $display("checks %0d errors %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : results

  task automatic timeout;
    bad_count++;
    $display("FAIL wait expected done seen hang");
    results();
  endtask : timeout

  // one classic cycle; read data taken at the ack edge, then one idle cycle
  task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] d);
    int n;
    n = 0;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we  <= we;
    wb_adr <= adr;
    wb_dat <= d;
    wb_sel <= 4'hf;
    do begin
      @(posedge mclk);
      n++;
    end while (wb_ack !== 1'b1 && n < 50);
    if (n >= 50) timeout();
    q = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we  <= 1'b0;
    @(posedge mclk);
  endtask : wb

  task automatic s_wd_reset;
    `WAITC(u_tmw_if.first_underflow_flag, 100)
    `CHK("second_flag_early", 1'b0, u_tmw_if.second_underflow_flag)
    `WAITC(u_tmw_if.wd_rst, 100)
    `CHK("second_flag", 1'b1, u_tmw_if.second_underflow_flag)
    @(posedge mclk);
    `CHK("pin_enable_n", 1'b0, rst_oe_n)
    k = 0;
    while (u_tmw_if.wd_rst === 1'b1 && k < 40) begin
      @(posedge mclk);
      k++;
    end
    `CHK("reset_length", int'(WDRST_CYC), k + 1)
    `CHK("flags_cleared", 2'b00, {u_tmw_if.first_underflow_flag, u_tmw_if.second_underflow_flag})
    `WAITC(u_tmw_if.first_underflow_flag, 100)
  endtask : s_wd_reset

  task automatic s_restart;
    wb(1'b1, ADR_CMD, cw(OP_WATCHDOG_RESTART_INSTR, TI_PS, 8'h00));
    // instruction issue, device skip and sticky status take two more edges
    repeat (2) @(posedge mclk);
    wb(1'b0, ADR_STAT, 32'h0);
    `CHK("skip_bit", 1'b1, q[ST_SKIP])
    `CHK("first_flag_clear", 1'b0, q[ST_FIRST_UNDERFLOW_FLAG])
    wb(1'b1, ADR_STAT, 32'h0000_c300);
  endtask : s_restart

  task automatic s_disable;
    wb(1'b1, ADR_CMD, cw(OP_WATCHDOG_DISABLE_INSTR, TI_PS, 8'h00));
    wb(1'b1, ADR_CMD, cw(OP_CLRWEF, TI_PS, 8'h00));
    k = 0;
    // two full periods would have ended in a watchdog reset
    while (u_tmw_if.wd_rst !== 1'b1 && k < 300) begin
      @(posedge mclk);
      k++;
    end
    `CHK("watchdog_off", 1'b0, u_tmw_if.wd_rst)
  endtask : s_disable

  task automatic s_timer_rw;
    wb(1'b1, ADR_CMD, cw(OP_T_WR, TI_T1, 8'h5a));
    wb(1'b1, ADR_CMD, cw(OP_T_RD, TI_T1, 8'h00));
    // read answer reaches the status word two edges after the order drains
    repeat (2) @(posedge mclk);
    wb(1'b0, ADR_STAT, 32'h0);
    `CHK("t1_count", 8'h5a, q[7:0])
    `CHK("no_error", 1'b0, q[ST_ERR])
    wb(1'b0, 4'hc, 32'h0);
    `CHK("unmapped_read", 32'h0, q)
  endtask : s_timer_rw

  task automatic s_event;
    wb(1'b1, ADR_CMD, cw(OP_T_WR, TI_T1, 8'h03));
    wb(1'b1, ADR_CMD, cw(OP_CTRL_WR, TI_T1, 8'h03));
    for (int i = 0; i < 4; i++) begin
      if (i == 3) begin
        wb(1'b0, ADR_STAT, 32'h0);
        `CHK("t1_early", 1'b0, q[ST_T1EV])
      end
      ev_pin <= 1'b1;
      repeat (4) @(posedge mclk);
      ev_pin <= 1'b0;
      repeat (4) @(posedge mclk);
    end
    wb(1'b0, ADR_STAT, 32'h0);
    `CHK("t1_event", 1'b1, q[ST_T1EV])
  endtask : s_event

  task automatic s_trigger;
    wb(1'b1, ADR_CMD, cw(OP_T_WR, TI_T3, 8'h08));
    wb(1'b1, ADR_CMD, cw(OP_CTRL_WR, TI_T3, 8'h06));
    repeat (20) @(posedge mclk);
    wb(1'b1, ADR_CMD, cw(OP_T_RD, TI_T3, 8'h00));
    wb(1'b0, ADR_STAT, 32'h0);
    `CHK("t3_waiting", 1'b0, q[ST_T3EV])
    `CHK("armed_read_refused", 1'b1, q[ST_ERR])
    trig <= 1'b1;
    repeat (4) @(posedge mclk);
    trig <= 1'b0;
    repeat (20) @(posedge mclk);
    wb(1'b0, ADR_STAT, 32'h0);
    `CHK("t3_event", 1'b1, q[ST_T3EV])
  endtask : s_trigger

  initial begin
    mclk = 1'b0;
    nrst = 1'b0;
    {wb_cyc, wb_stb, wb_we, ev_pin, trig} = 5'h00;
    wb_adr = 4'h0;
    wb_sel = 4'h0;
    wb_dat = 32'h0;
    bad_count = 0;
    n_checks = 0;
    repeat (4) @(posedge mclk);
    nrst <= 1'b1;
    s_wd_reset();
    s_restart();
    s_disable();
    s_timer_rw();
    s_event();
    s_trigger();
    results();
  end

  initial begin
    repeat (90000) @(posedge mclk);
    timeout();
  end
endmodule : test_timer_watchdog_control
`default_nettype wire

/* verif/tmw_asserts.sv */
// tmw_asserts: watchdog and link checks on the core/device instruction link
// assumes one clock domain, synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module tmw_asserts
  import tmw_pkg::*;
#(
  parameter logic [15:0] WDT_INIT = WDT_INIT_DEF
) (
  input wire logic       mclk,
  input wire logic       nrst,
  input wire logic       cmd_valid,
  input wire logic [3:0] cmd_op,
  input wire logic       rd_valid,
  input wire logic       skip,
  input wire logic       first_underflow_flag,
  input wire logic       second_underflow_flag,
  input wire logic       wd_rst,
  input wire logic       rst_pin_oe_n
);
  logic [17:0] age_q;
  logic [7:0]  len_q;
  logic        watchdog_restart_instr;
  logic        rdreq;
  assign watchdog_restart_instr  = cmd_valid && cmd_op == OP_WATCHDOG_RESTART_INSTR;
  assign rdreq = cmd_valid && cmd_op == OP_T_RD;
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  // saturates so the first-underflow window is only seen once
  always_ff @(posedge mclk) begin
    if (!nrst) age_q <= '0;
    else if (age_q != '1) age_q <= age_q + 18'h1;
  end
  always_ff @(posedge mclk) begin
    if (!nrst || !wd_rst) len_q <= '0;
    else len_q <= len_q + 8'h1;
  end
  AST_WD_QUIET_EARLY: assert property (age_q < {2'h0, WDT_INIT} |-> !first_underflow_flag && !wd_rst)
    else $error("watchdog flag before its count ran out");
  AST_WD_FIRST_UF: assert property (age_q == {2'h0, WDT_INIT} + 18'h3 |-> first_underflow_flag)
    else $error("first underflow flag missing");
  AST_SKIP_AFTER_WATCHDOG_RESTART_INSTR: assert property (watchdog_restart_instr |=> skip)
    else $error("restart gave no skip");
  AST_SKIP_CAUSE: assert property (skip |-> $past(watchdog_restart_instr))
    else $error("skip without restart");
  AST_FIRST_UNDERFLOW_FLAG_FALL: assert property ($fell(first_underflow_flag) |-> $past(watchdog_restart_instr) || $past(wd_rst))
    else $error("first flag cleared without cause");
  AST_SECOND_UNDERFLOW_FLAG_CAUSE: assert property ($rose(second_underflow_flag) |-> $past(first_underflow_flag) && wd_rst)
    else $error("second flag without first flag");
  AST_WDRST_PIN: assert property ($rose(wd_rst) |-> ##[0:1] !rst_pin_oe_n)
    else $error("reset pin not driven");
  AST_PIN_CAUSE: assert property (!rst_pin_oe_n |-> wd_rst || $past(wd_rst))
    else $error("reset pin driven without watchdog reset");
  AST_WDRST_LEN: assert property ($fell(wd_rst) |-> len_q == WDRST_CYC)
    else $error("watchdog reset length wrong");
  AST_FLAGS_CLEAR: assert property ($fell(wd_rst) |-> !first_underflow_flag && !second_underflow_flag)
    else $error("flags kept after watchdog reset");
  AST_RD_ANSWER: assert property (rdreq |=> rd_valid)
    else $error("timer read not answered");
  cover property ($rose(wd_rst));
  cover property (skip);
  cover property (rd_valid);
endmodule : tmw_asserts
`default_nettype wire
